// *** design/ssfpd_decoder.sv ***
// shared sent function pulse decoder with apb control
// Operation
// (RULE1) function is chosen only by the length of the host's low pulse in ticks
// (RULE2) sequential mode: respond only to requesting pulse when slot equals own id
// (RULE3) keep line high at least 7 ticks after pulse before starting frame
// (RULE4) stretch that gap so 70.4 us pass from pulse rise to sync end
// (RULE5) output request returns held sample if pending, else fresh sample
// (RULE6) hold-on-slot-zero set: sample and hold at output pulse for slot zero
// (RULE7) hold disabled and no slot-zero hold: never hold, always fresh data
// (RULE8) sample pulse latches data at rise unless hold disabled
// (RULE9) sample addressing 0 is silent broadcast; 1 also addresses a responder
// (RULE10) diag addressing 0: silent broadcast, self-test unless self-test disallowed
// (RULE11) diag addressing 1: addressed sensor starts self-test if allowed, no frame
// (RULE12) slot sync pulse makes next addressing pulse slot zero
// (RULE13) narrow set: 15-19 output, 31-39 sample, 56-70 diag, 93-115 sync
// (RULE14) wide set: 9-81 output, 105-171 sync, 216-264 diag, no sample
// (RULE15) addressed mode: 15-19 output, 31-39 sample, 56-70 diag, no sync
// (RULE16) host sends zero to three id increment pulses after addressing pulse
// (RULE17) id increments end after line stays high about 18 ticks
// (RULE18) stretch that 18-tick gap to keep 70.4 us processing time
// (RULE19) addressed mode: only id equal to increment count responds
// (RULE20) all sensors on a bus should share sample addressing settings
// (RULE21) sequential mode: slot advances on addressing pulses, wraps past sensor total
// (RULE22) broadcast-only pulses leave slot tally unchanged
// (RULE23) widths outside every window are ignored without any state change; the code still writes FN_NONE to last_fn and pend_fn and clears inc_count
// (RULE24) low width counted in configured ticks from fall to rise
`timescale 1ns/10ps
`default_nettype none
`include "ssfpd_defines.svh"
module ssfpd_decoder #(
    parameter int LOW_W = 9
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sent_line,
    output logic sample_hold,
    output logic fresh_sample,
    output logic frame_start,
    output logic frame_use_held,
    output logic diag_start
);
    import ssfpd_pkg::*;

    // the widest window tops out at 264 ticks
    if (LOW_W < 9 || LOW_W > 16) begin : bad_low_w
        $error("LOW_W must be between 9 and 16");
    end

    localparam logic [LOW_W-1:0] LOW_SAT = {LOW_W{1'b1}};
    localparam logic [23:0] MIN_PROC = 24'(`SSFPD_MIN_PROC_CYC);

    // registers
    logic [31:0] ctrl;
    ssfpd_tick_t tick_period;
    logic [1:0] slot_tally;
    logic held_valid;
    ssfpd_state_e state;
    ssfpd_fn_e pend_fn;
    ssfpd_fn_e last_fn;
    logic [LOW_W-1:0] low_ticks;
    logic [4:0] high_ticks;
    logic [10:0] elapsed;
    logic [2:0] inc_count;
    logic line_meta;
    logic line_sync;
    logic line_prev;

    ssfpd_tick_if tif ();

    ssfpd_tick_gen u_tick (
        .pclk(pclk),
        .presetn(presetn),
        .tif(tif)
    );

    // control fields
    wire addressed = ctrl[`SSFPD_CTRL_ADDRESSED];
    wire [2:0] outmsg = ctrl[`SSFPD_CTRL_OUTMSG_HI:`SSFPD_CTRL_OUTMSG_LO];
    wire zero_sample = ctrl[`SSFPD_CTRL_ZERO_SAMPLE];
    wire no_sample = ctrl[`SSFPD_CTRL_NO_SAMPLE];
    wire sample_adr = ctrl[`SSFPD_CTRL_SAMPLE_ADR];
    wire diag_adr = ctrl[`SSFPD_CTRL_DIAG_ADR];
    wire diag_enable = ctrl[`SSFPD_CTRL_DIAG_ENABLE];
    wire [1:0] sensor_id = ctrl[`SSFPD_CTRL_ID_HI:`SSFPD_CTRL_ID_LO];
    wire [1:0] max_sensor = ctrl[`SSFPD_CTRL_MAXS_HI:`SSFPD_CTRL_MAXS_LO];

    // line edges, read only from the second synchroniser stage
    wire fall_evt = line_prev & ~line_sync;
    wire rise_evt = ~line_prev & line_sync;
    assign tif.restart = fall_evt | rise_evt;
    assign tif.period = tick_period;

    // width windows
    wire [8:0] lw = 9'(low_ticks > LOW_W'(9'h1FF) ? LOW_W'(9'h1FF) : low_ticks);
    wire n_out = (lw >= `SSFPD_N_OUT_MIN) && (lw <= `SSFPD_N_OUT_MAX);
    wire n_smp = (lw >= `SSFPD_N_SMP_MIN) && (lw <= `SSFPD_N_SMP_MAX);
    wire n_diag = (lw >= `SSFPD_N_DIAG_MIN) && (lw <= `SSFPD_N_DIAG_MAX);
    wire n_sync = (lw >= `SSFPD_N_SYNC_MIN) && (lw <= `SSFPD_N_SYNC_MAX);
    wire w_out = (lw >= `SSFPD_W_OUT_MIN) && (lw <= `SSFPD_W_OUT_MAX);
    wire w_sync = (lw >= `SSFPD_W_SYNC_MIN) && (lw <= `SSFPD_W_SYNC_MAX);
    wire w_diag = (lw >= `SSFPD_W_DIAG_MIN) && (lw <= `SSFPD_W_DIAG_MAX);
    // saturated counts never match a window, so overlong pulses fall out
    wire sat = (low_ticks == LOW_SAT);
    wire set_narrow = ~addressed && (outmsg == `SSFPD_OUTMSG_NARROW);
    wire set_wide = ~addressed && (outmsg == `SSFPD_OUTMSG_WIDE);

    // classify the finished low pulse [RULE1] [RULE13] [RULE14] [RULE15]
    ssfpd_fn_e fn;
    always_comb begin
        fn = FN_NONE;
        if (sat) begin
            fn = FN_NONE; // [RULE23]
        end else if (addressed) begin
            if (n_out) fn = FN_OUTPUT;
            else if (n_smp) fn = FN_SAMPLE;
            else if (n_diag) fn = FN_DIAG;
        end else if (set_narrow) begin
            if (n_out) fn = FN_OUTPUT;
            else if (n_smp) fn = FN_SAMPLE;
            else if (n_diag) fn = FN_DIAG;
            else if (n_sync) fn = FN_SYNC;
        end else if (set_wide) begin
            if (w_out) fn = FN_OUTPUT;
            else if (w_sync) fn = FN_SYNC;
            else if (w_diag) fn = FN_DIAG;
        end
    end

    // pulse roles; sample and diag addressing are per-sensor settings [RULE9] [RULE20]
    wire is_addr = (fn == FN_OUTPUT) || (fn == FN_SAMPLE && sample_adr)
        || (fn == FN_DIAG && diag_adr);
    wire wants_frame = (fn == FN_OUTPUT) || (fn == FN_SAMPLE && sample_adr);
    wire slot_match = (slot_tally == sensor_id);
    wire [1:0] slot_adv = (slot_tally >= max_sensor) ? 2'h0 : slot_tally + 2'h1;
    // slot-zero hold overrides hold-disabled, matching the documented combination
    wire do_hold = ((fn == FN_SAMPLE) && ~no_sample)
        || ((fn == FN_OUTPUT) && zero_sample && ~addressed && slot_tally == 2'h0);
    wire bcast_diag = (fn == FN_DIAG) && ~diag_adr && diag_enable;

    // gap ends when enough ticks passed and the frame sync would close after 70.4 us
    wire [21:0] sync_cyc = 22'(tick_period) * 22'(`SSFPD_SYNC_PULSE_TICKS);
    wire proc_ok = (24'(elapsed) + 24'(sync_cyc)) >= MIN_PROC;
    wire resp_gap_ok = (high_ticks >= `SSFPD_RESP_GAP_TICKS) && proc_ok;
    wire addr_gap_ok = (high_ticks >= `SSFPD_ADDR_END_TICKS) && proc_ok;
    wire id_match = (inc_count == {1'b0, sensor_id});
    wire elapsed_sat = (elapsed == 11'h7FF);

    // apb decode; zero wait states
    wire setup_ph = psel & ~penable;
    wire wr_acc = psel & penable & pwrite & pready;
    wire hit_ctrl = (paddr == `SSFPD_CTRL_OFS);
    wire hit_tick = (paddr == `SSFPD_TICK_OFS);
    wire hit_stat = (paddr == `SSFPD_STAT_OFS);
    wire hit_any = hit_ctrl | hit_tick | hit_stat;
    wire [31:0] stat_word = {19'h0, 3'(last_fn), 3'(pend_fn), inc_count, held_valid,
        (state != ST_IDLE), slot_tally};
    wire [31:0] rd_mux = hit_ctrl ? ctrl : hit_tick ? {16'h0, tick_period}
        : hit_stat ? stat_word : 32'h0000_0000;

    // two-flop synchroniser on the shared line; prev tracks the synced level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_meta <= 1'b1;
            line_sync <= 1'b1;
            line_prev <= 1'b1;
        end else begin
            line_meta <= sent_line;
            line_sync <= line_meta;
            line_prev <= line_sync;
        end
    end

    // apb register file; answer data is loaded in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= `SSFPD_CTRL_RST;
            tick_period <= `SSFPD_TICK_RST;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
            pready <= 1'b0;
        end else begin
            pready <= 1'b1;
            if (setup_ph) begin
                prdata <= pwrite ? 32'h0000_0000 : rd_mux;
                pslverr <= ~hit_any;
            end
            if (wr_acc && hit_ctrl) ctrl <= pwdata & `SSFPD_CTRL_MASK;
            if (wr_acc && hit_tick) tick_period <= pwdata[15:0];
        end
    end

    // width and gap counters advanced by the tick strobe, elapsed by every pclk cycle [RULE24]
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_ticks <= '0;
            high_ticks <= 5'h00;
            elapsed <= 11'h000;
        end else begin
            if (fall_evt) low_ticks <= '0;
            else if (tif.tick && !line_sync && low_ticks != LOW_SAT) begin
                low_ticks <= low_ticks + LOW_W'(1);
            end
            if (rise_evt) high_ticks <= 5'h00;
            else if (tif.tick && line_sync && high_ticks != 5'h1F) high_ticks <= high_ticks + 5'h01;
            // elapsed counts from the pulse's rising edge
            if (rise_evt && state == ST_LOW) elapsed <= 11'h000;
            else if (!elapsed_sat) elapsed <= elapsed + 11'h001;
        end
    end

    // pulse decoder state machine and its one-cycle action strobes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_IDLE;
            slot_tally <= 2'h0;
            held_valid <= 1'b0;
            pend_fn <= FN_NONE;
            last_fn <= FN_NONE;
            inc_count <= 3'h0;
            sample_hold <= 1'b0;
            fresh_sample <= 1'b0;
            frame_start <= 1'b0;
            frame_use_held <= 1'b0;
            diag_start <= 1'b0;
        end else begin
            sample_hold <= 1'b0;
            fresh_sample <= 1'b0;
            frame_start <= 1'b0;
            diag_start <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (fall_evt) state <= ST_LOW;
                end
                ST_LOW: begin
                    if (rise_evt) begin
                        last_fn <= fn;
                        pend_fn <= fn;
                        inc_count <= 3'h0;
                        state <= ST_IDLE;
                        if (fn != FN_NONE) begin
                            if (do_hold) begin
                                sample_hold <= 1'b1; // [RULE6] [RULE7] [RULE8]
                                held_valid <= 1'b1;
                            end
                            if (bcast_diag) diag_start <= 1'b1; // [RULE10]
                        end
                        if (fn != FN_NONE && addressed && is_addr) begin
                            state <= ST_ADDR; // [RULE16]
                        end else if (fn != FN_NONE && !addressed) begin
                            if (fn == FN_SYNC) slot_tally <= 2'h0; // [RULE12]
                            if (is_addr) slot_tally <= slot_adv; // [RULE21] [RULE22]
                            if (is_addr && slot_match) begin
                                if (fn == FN_DIAG) diag_start <= diag_enable; // [RULE11]
                                else if (wants_frame) state <= ST_GAP; // [RULE2]
                            end
                        end
                    end
                end
                ST_ADDR: begin
                    // count increment pulses; a fifth one can never match any id
                    if (fall_evt && inc_count != 3'h4) inc_count <= inc_count + 3'h1;
                    if (line_sync && addr_gap_ok) begin // [RULE17] [RULE18]
                        state <= ST_IDLE;
                        if (id_match) begin // [RULE19]
                            if (pend_fn == FN_DIAG) begin
                                diag_start <= diag_enable; // [RULE11]
                            end else begin
                                frame_start <= 1'b1; // [RULE5]
                                frame_use_held <= held_valid;
                                fresh_sample <= ~held_valid;
                                held_valid <= 1'b0;
                            end
                        end
                    end
                end
                ST_GAP: begin
                    if (fall_evt) begin
                        // someone else pulled the line; treat it as a new pulse
                        state <= ST_LOW;
                    end else if (resp_gap_ok) begin // [RULE3] [RULE4]
                        state <= ST_IDLE;
                        frame_start <= 1'b1; // [RULE5]
                        frame_use_held <= held_valid;
                        fresh_sample <= ~held_valid;
                        held_valid <= 1'b0;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end
endmodule : ssfpd_decoder
`default_nettype wire

// *** design/ssfpd_defines.svh ***
// offsets, field positions, reset values and timing counts of the pulse decoder
`ifndef SSFPD_DEFINES_SVH
`define SSFPD_DEFINES_SVH

// register byte offsets
`define SSFPD_CTRL_OFS 12'h000
`define SSFPD_TICK_OFS 12'h004
`define SSFPD_STAT_OFS 12'h008

// control register fields
`define SSFPD_CTRL_ADDRESSED 0
`define SSFPD_CTRL_OUTMSG_LO 2
`define SSFPD_CTRL_OUTMSG_HI 4
`define SSFPD_CTRL_ZERO_SAMPLE 5
`define SSFPD_CTRL_NO_SAMPLE 6
`define SSFPD_CTRL_SAMPLE_ADR 7
`define SSFPD_CTRL_DIAG_ADR 8
`define SSFPD_CTRL_DIAG_ENABLE 9
`define SSFPD_CTRL_ID_LO 10
`define SSFPD_CTRL_ID_HI 11
`define SSFPD_CTRL_MAXS_LO 12
`define SSFPD_CTRL_MAXS_HI 13
`define SSFPD_CTRL_MASK 32'h0000_3FFD

// reset values
`define SSFPD_CTRL_RST 32'h0000_3210
`define SSFPD_TICK_RST 16'h0014

// pulse set selections
`define SSFPD_OUTMSG_NARROW 3'h4
`define SSFPD_OUTMSG_WIDE 3'h3

// low-width windows in ticks
`define SSFPD_N_OUT_MIN 9'h00F
`define SSFPD_N_OUT_MAX 9'h013
`define SSFPD_N_SMP_MIN 9'h01F
`define SSFPD_N_SMP_MAX 9'h027
`define SSFPD_N_DIAG_MIN 9'h038
`define SSFPD_N_DIAG_MAX 9'h046
`define SSFPD_N_SYNC_MIN 9'h05D
`define SSFPD_N_SYNC_MAX 9'h073
`define SSFPD_W_OUT_MIN 9'h009
`define SSFPD_W_OUT_MAX 9'h051
`define SSFPD_W_SYNC_MIN 9'h069
`define SSFPD_W_SYNC_MAX 9'h0AB
`define SSFPD_W_DIAG_MIN 9'h0D8
`define SSFPD_W_DIAG_MAX 9'h108

// high gaps and frame sync pulse length in ticks
`define SSFPD_RESP_GAP_TICKS 5'h07
`define SSFPD_ADDR_END_TICKS 5'h12
`define SSFPD_SYNC_PULSE_TICKS 6'h38

// processing time: least time rounds up to whole cycles
`define SSFPD_CLK_PERIOD_NS 50
`define SSFPD_MIN_PROC_NS 70400
`define SSFPD_MIN_PROC_CYC ((`SSFPD_MIN_PROC_NS + `SSFPD_CLK_PERIOD_NS - 1) / `SSFPD_CLK_PERIOD_NS)

`endif

// *** design/ssfpd_pkg.sv ***
// types shared by the pulse decoder files
package ssfpd_pkg;
    typedef enum logic [2:0] {
        FN_NONE,
        FN_OUTPUT,
        FN_SAMPLE,
        FN_DIAG,
        FN_SYNC
    } ssfpd_fn_e;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_LOW,
        ST_ADDR,
        ST_GAP
    } ssfpd_state_e;

    typedef logic [15:0] ssfpd_tick_t;
endpackage : ssfpd_pkg

// *** design/ssfpd_tick_if.sv ***
// tick strobe carrier between the decoder and its tick divider
`timescale 1ns/10ps
`default_nettype none
interface ssfpd_tick_if;
    import ssfpd_pkg::*;
    ssfpd_tick_t period;
    logic restart;
    logic tick;
    modport gen (input period, input restart, output tick);
    modport user (output period, output restart, input tick);
endinterface : ssfpd_tick_if
`default_nettype wire

// *** design/ssfpd_tick_gen.sv ***
// divider that turns pclk into one-cycle tick strobes of a programmed period
`timescale 1ns/10ps
`default_nettype none
module ssfpd_tick_gen (
    input wire logic pclk,
    input wire logic presetn,
    ssfpd_tick_if.gen tif
);
    import ssfpd_pkg::*;

    ssfpd_tick_t cnt;
    ssfpd_tick_t last;
    logic wrap;

    // a period of zero behaves as one so the strobe never stops
    assign last = (tif.period == 16'h0000) ? 16'h0000 : tif.period - 16'h0001;
    assign wrap = (cnt >= last);

    // restart aligns the tick phase to a line edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 16'h0000;
            tif.tick <= 1'b0;
        end else if (tif.restart) begin
            cnt <= 16'h0000;
            tif.tick <= 1'b0;
        end else begin
            cnt <= wrap ? 16'h0000 : cnt + 16'h0001;
            tif.tick <= wrap;
        end
    end
endmodule : ssfpd_tick_gen
`default_nettype wire

// *** tb/ssfpd_decoder_properties.sv ***
// concurrent checks on the pulse decoder ports
`timescale 1ns/10ps
`default_nettype none
`include "ssfpd_defines.svh"
module ssfpd_decoder_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic sent_line,
    input wire logic sample_hold,
    input wire logic fresh_sample,
    input wire logic frame_start,
    input wire logic frame_use_held,
    input wire logic diag_start
);
    import ssfpd_pkg::*;
    logic [31:0] ctrl_sh;
    logic [15:0] tick_sh;
    int hi_cnt;
    wire logic apb_wr = psel && penable && pwrite && pready;
    // settings shadowed from completed writes, since gap lengths depend on them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_sh <= `SSFPD_CTRL_RST;
            tick_sh <= `SSFPD_TICK_RST;
        end else if (apb_wr && paddr == 12'h000) begin
            ctrl_sh <= pwdata & `SSFPD_CTRL_MASK;
        end else if (apb_wr && paddr == 12'h004) begin
            tick_sh <= pwdata[15:0];
        end
    end
    // cycles the pin has stayed high; saturates so a long idle cannot wrap
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hi_cnt <= 0;
        end else if (!sent_line) begin
            hi_cnt <= 0;
        end else if (hi_cnt < 100000) begin
            hi_cnt <= hi_cnt + 1;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_rise; $rose(sent_line); endsequence
    sequence s_quiet; !frame_start [*8]; endsequence
    property p_no_early; s_rise |-> s_quiet; endproperty
    a_no_early: assert property (p_no_early) else $error("frame right after rise");
    property p_resp_gap; frame_start |-> hi_cnt >= 7 * int'(tick_sh); endproperty
    a_resp_gap: assert property (p_resp_gap) else $error("response gap short");
    property p_proc;
        frame_start |-> hi_cnt + 56 * int'(tick_sh) >= `SSFPD_MIN_PROC_CYC;
    endproperty
    a_proc: assert property (p_proc) else $error("processing time short");
    property p_addr_gap;
        ctrl_sh[0] && (frame_start || diag_start && ctrl_sh[8]) |-> hi_cnt >= 18 * int'(tick_sh);
    endproperty
    a_addr_gap: assert property (p_addr_gap) else $error("address end gap short");
    property p_hold_at_rise; sample_hold |-> hi_cnt inside {[1:8]}; endproperty
    a_hold_at_rise: assert property (p_hold_at_rise) else $error("hold not at rise");
    property p_no_hold; ctrl_sh[6] && !ctrl_sh[5] |-> !sample_hold; endproperty
    a_no_hold: assert property (p_no_hold) else $error("hold while disabled");
    property p_fresh; fresh_sample |-> frame_start; endproperty
    a_fresh: assert property (p_fresh) else $error("fresh sample without frame");
    property p_source; frame_start |-> fresh_sample != frame_use_held; endproperty
    a_source: assert property (p_source) else $error("frame data source wrong");
    property p_diag_off; !ctrl_sh[9] |-> !diag_start; endproperty
    a_diag_off: assert property (p_diag_off) else $error("self-test while disallowed");
    property p_diag_now; diag_start && !ctrl_sh[8] |-> hi_cnt inside {[1:8]} && !frame_start;
    endproperty
    a_diag_now: assert property (p_diag_now) else $error("broadcast self-test late");
endmodule : ssfpd_decoder_chk
bind ssfpd_decoder ssfpd_decoder_chk chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sent_line(sent_line), .sample_hold(sample_hold),
    .fresh_sample(fresh_sample), .frame_start(frame_start), .frame_use_held(frame_use_held),
    .diag_start(diag_start));
`default_nettype wire

// *** tb/ssfpd_host_model.sv ***
// host controller model that pulls the shared line low for function pulses
`timescale 1ns/10ps
`default_nettype none
module ssfpd_host_model #(
    parameter int INC_LOW_TICKS = 4,
    parameter int INC_HIGH_TICKS = 4
) (
    input wire logic pclk,
    output logic sent_line
);
    // pulled-up line: the host only pulls low, released it reads high
    initial sent_line = 1'b1;
    // low for a count of cycles, changed just after edges
    task automatic hold_low(input int cycles);
        sent_line <= 1'b0;
        repeat (cycles) @(posedge pclk);
        sent_line <= 1'b1;
    endtask : hold_low
    // half a tick extra keeps the floored count at the nominal width for ticks of 4 cycles or more; at a 2-cycle tick it lands one short
    task automatic send(input int ticks, input int tick, input int incs);
        @(posedge pclk);
        hold_low(ticks * tick + tick / 2);
        for (int i = 0; i < incs; i++) begin
            repeat (INC_HIGH_TICKS * tick) @(posedge pclk);
            hold_low(INC_LOW_TICKS * tick);
        end
    endtask : send
endmodule : ssfpd_host_model
`default_nettype wire

// *** tb/tb_top.sv ***
// self-checking bench for the pulse decoder with an event scoreboard
`timescale 1ns/10ps
`default_nettype none
`include "ssfpd_defines.svh"
`define SSFPD_CHK(what, exp, got) begin n_compared++; if ((got) !== (exp)) begin \
    n_fail++; $display("ERROR %s expected %0h seen %0h", what, exp, got); end end
module tb_top;
    import ssfpd_pkg::*;
    localparam logic [4:0] E_SH = 5'h10, E_FR = 5'h0A, E_FH = 5'h0C, E_DG = 5'h01;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, sent_line;
    logic sample_hold, fresh_sample, frame_start, frame_use_held, diag_start;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [4:0] exp_q[$];
    logic [4:0] got, want;
    int n_fail = 0, n_compared = 0, cyc = 0, tick = 20;
    int bad[4] = '{12, 25, 47, 80};
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    ssfpd_decoder uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sent_line(sent_line), .sample_hold(sample_hold),
        .fresh_sample(fresh_sample), .frame_start(frame_start),
        .frame_use_held(frame_use_held), .diag_start(diag_start));
    ssfpd_host_model host (.pclk(pclk), .sent_line(sent_line));
    // one transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // no wait-state count assumed; only the hang guard ends a stuck access
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // one sensor on the bus, so its settings agree with themselves
    task automatic cfg(input logic [31:0] c);
        apb(1'b1, 12'h000, c);
    endtask : cfg
    task automatic slot_is(input logic [1:0] s);
        apb(1'b0, 12'h008, 32'h0);
        `SSFPD_CHK("slot", s, rd[1:0])
    endtask : slot_is
    // note the expected strobes, send the pulse, then poll busy with a bound
    task automatic fn(input int t, input int incs, input logic [4:0] e0 = 5'h00,
        input logic [4:0] e1 = 5'h00);
        int n = 0;
        if (e0 != 5'h00) exp_q.push_back(e0);
        if (e1 != 5'h00) exp_q.push_back(e1);
        host.send(t, tick, incs);
        repeat (8) @(posedge pclk);
        apb(1'b0, 12'h008, 32'h0);
        // busy sits at bit 2; bit 3 is the held-sample flag
        while (rd[2] !== 1'b0 && n < 500) begin
            apb(1'b0, 12'h008, 32'h0);
            n++;
        end
        `SSFPD_CHK("busy", 1'b0, rd[2])
    endtask : fn
    task automatic done(input string s);
        $display("test %s finished", s);
    endtask : done
    task automatic conclude();
        `SSFPD_CHK("missing events", 0, exp_q.size())
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : conclude
    // every strobe takes the oldest note; a strobe with no note is a mismatch
    always @(posedge pclk) begin
        got = {sample_hold, frame_start, frame_use_held & frame_start, fresh_sample, diag_start};
        if (presetn === 1'b1 && got !== 5'h00) begin
            want = (exp_q.size() > 0) ? exp_q.pop_front() : 5'h00;
            `SSFPD_CHK("event", want, got)
        end
    end
    // hang guard, well above the roughly 50k cycles the sequence needs
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 95000) begin
            n_fail++;
            conclude();
        end
    end
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        presetn = 1'b0;
        rd = $urandom(32'h674c);
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        apb(1'b0, 12'h000, 32'h0);
        `SSFPD_CHK("ctrl reset", `SSFPD_CTRL_RST, rd)
        apb(1'b0, 12'h004, 32'h0);
        `SSFPD_CHK("tick reset", 32'h0000_0014, rd)
        apb(1'b0, 12'h00C, 32'h0);
        `SSFPD_CHK("unmapped error", 1'b1, err)
        done("registers");
        fn(104, 0);
        slot_is(2'h0);
        for (int i = 0; i < 5; i++) begin
            fn($urandom_range(18, 16), 0, (i % 4 == 0) ? E_FR : 5'h00);
        end
        slot_is(2'h1);
        foreach (bad[i]) fn(bad[i], 0);
        slot_is(2'h1);
        done("slots");
        fn(104, 0);
        slot_is(2'h0);
        fn(35, 0, E_SH);
        fn(63, 0, E_DG);
        slot_is(2'h0);
        fn(17, 0, E_FH);
        done("broadcast");
        cfg(32'h0000_3230);
        fn(104, 0);
        fn(17, 0, E_SH, E_FH);
        cfg(32'h0000_3250);
        fn(104, 0);
        fn(35, 0);
        fn(17, 0, E_FR);
        done("hold options");
        cfg(32'h0000_3010);
        fn(63, 0);
        cfg(32'h0000_3310);
        fn(104, 0);
        fn(63, 0, E_DG);
        fn(63, 0);
        cfg(32'h0000_3290);
        fn(104, 0);
        fn(35, 0, E_SH, E_FH);
        done("addressing options");
        cfg(32'h0000_320C);
        fn(140, 0);
        fn($urandom_range(80, 10), 0, E_FR);
        fn(240, 0, E_DG);
        done("wide set");
        cfg(32'h0000_3A11);
        fn(17, 2, E_FR);
        fn(17, 1);
        fn(104, 0);
        fn(35, 3, E_SH);
        fn(17, 2, E_FH);
        done("addressed");
        apb(1'b1, 12'h004, 32'h0000_0002);
        tick = 2;
        cfg(32'h0000_3210);
        fn(104, 0);
        fn(17, 0, E_FR);
        done("short tick");
        conclude();
    end
endmodule : tb_top
`default_nettype wire
